// >>> verilog/cpusr_regs.svh
`ifndef CPUSR_REGS_SVH
`define CPUSR_REGS_SVH
// Register byte offsets on the bus
`define CPUSR_OFF_IP      8'h00
`define CPUSR_OFF_ACC     8'h04
`define CPUSR_OFF_TMP     8'h08
`define CPUSR_OFF_IX      8'h0c
`define CPUSR_OFF_EP      8'h10
`define CPUSR_OFF_SP      8'h14
`define CPUSR_OFF_PSW     8'h18
`define CPUSR_OFF_ALU     8'h1c
`define CPUSR_OFF_IRQ     8'h20
`define CPUSR_OFF_GPR     8'h24
`define CPUSR_OFF_MAP     8'h28
// Flag positions in the condition flags
`define CPUSR_BIT_H       7
`define CPUSR_BIT_I       6
`define CPUSR_BIT_IL1     5
`define CPUSR_BIT_IL0     4
`define CPUSR_BIT_N       3
`define CPUSR_BIT_Z       2
`define CPUSR_BIT_V       1
`define CPUSR_BIT_C       0
// Reset values
`define CPUSR_RST_PSW     16'h0030
`define CPUSR_RST_SP      16'h0000
`define CPUSR_RST_IP      16'hfffd
// Memory map
`define CPUSR_IO_TOP      16'h007f
`define CPUSR_DATA_TOP    16'h7fff
`define CPUSR_BANK_BASE   16'h0100
`define CPUSR_BANK_LIMIT  5'd8
`endif

// >>> verilog/cpusr_pkg.sv
package cpusr_pkg;
    typedef enum logic [2:0] {
        CPUSR_OP_ADD,
        CPUSR_OP_SUB,
        CPUSR_OP_SHL,
        CPUSR_OP_SHR,
        CPUSR_OP_PASS
    } cpusr_op_t;
    typedef enum logic [1:0] {
        CPUSR_RGN_IO,
        CPUSR_RGN_DATA,
        CPUSR_RGN_PROG
    } cpusr_rgn_t;
    typedef enum logic [1:0] {
        CPUSR_WR_IDLE,
        CPUSR_WR_RESP
    } cpusr_wr_t;
endpackage

// >>> verilog/cpusr_core.sv
`timescale 1ns/1ps
// What this block does
// - One 64 Kbyte space holds I/O, data and program regions.
// - I/O region lowest, data region directly above it.
// - Program region at top; vectors fetched from highest addresses.
// - Instruction pointer is a 16-bit register of the fetch address.
// - Accumulator is 16 bits; 8-bit operations touch only its low byte.
// - Second operand is 16 bits; 8-bit operations use its low byte.
// - Index, extra and stack-top pointers are each 16 bits.
// - Status word: upper byte bank select, lower byte condition flags.
// - Half-carry flags carry or borrow between bit 3 and bit 4.
// - Interrupt enable permits when 1, blocks when 0, reset to 0.
// - Request accepted only when its level beats the mask level.
// - Mask level 1 highest, then 2, 3 lowest; 1 accepts nothing.
// - Negative flag copies the result's most significant bit.
// - Zero flag set when result is zero, else cleared.
// - Overflow flag set on two's-complement overflow, else cleared.
// - Carry records carry or borrow out of bit 7 (bit 15 in 16-bit ops), or shifted-out bit.
// - General registers 8 bits, eight per bank, up to 16 banks.
// - Bank select pointer picks the active register bank.
// - Only the lower half of the banks is implemented here.
`include "cpusr_regs.svh"
module cpusr_core (
    input  wire logic               i_sys_clk,
    input  wire logic               i_rstn,
    input  wire logic [7:0]         i_s_axi_awaddr,
    input  wire logic               i_s_axi_awvalid,
    output logic                    o_s_axi_awready,
    input  wire logic [31:0]        i_s_axi_wdata,
    input  wire logic [3:0]         i_s_axi_wstrb,
    input  wire logic               i_s_axi_wvalid,
    output logic                    o_s_axi_wready,
    output logic [1:0]              o_s_axi_bresp,
    output logic                    o_s_axi_bvalid,
    input  wire logic               i_s_axi_bready,
    input  wire logic [7:0]         i_s_axi_araddr,
    input  wire logic               i_s_axi_arvalid,
    output logic                    o_s_axi_arready,
    output logic [31:0]             o_s_axi_rdata,
    output logic [1:0]              o_s_axi_rresp,
    output logic                    o_s_axi_rvalid,
    input  wire logic               i_s_axi_rready,
    input  wire logic               i_alu_go,
    input  wire cpusr_pkg::cpusr_op_t i_alu_op,
    input  wire logic               i_alu_wide,
    input  wire logic [1:0]         i_irq_level,
    input  wire logic               i_irq_req,
    input  wire logic [2:0]         i_gpr_index,
    input  wire logic [15:0]        i_mem_addr,
    output logic                    o_irq_accept,
    output logic [15:0]             o_gpr_addr,
    output logic                    o_gpr_valid,
    output logic [1:0]              o_mem_region
);
    import cpusr_pkg::*;

    // Region decode, used for bus view and output
    function automatic cpusr_rgn_t region_of(input logic [15:0] a);
        if (a <= `CPUSR_IO_TOP)
            region_of = CPUSR_RGN_IO;
        else if (a <= `CPUSR_DATA_TOP)
            region_of = CPUSR_RGN_DATA;
        else
            region_of = CPUSR_RGN_PROG;
    endfunction

    function automatic logic level_ok(input logic [1:0] req,
                                      input logic [1:0] mask);
        level_ok = (req != 2'b11)
                 && ((req | {1'b0, ~|req}) < (mask | {1'b0, ~|mask}));
    endfunction

    logic [15:0] ip_ff, nxt_ip;
    logic [15:0] acc_ff, nxt_acc;
    logic [15:0] tmp_ff, nxt_tmp;
    logic [15:0] ix_ff, nxt_ix;
    logic [15:0] ep_ff, nxt_ep;
    logic [15:0] sp_ff, nxt_sp;
    logic [15:0] psw_ff, nxt_psw;
    logic [1:0]  rlvl_ff, nxt_rlvl;
    logic [2:0]  ridx_ff, nxt_ridx;
    cpusr_wr_t   wst_ff, nxt_wst;
    logic        aw_got_ff, nxt_aw_got;
    logic        w_got_ff, nxt_w_got;
    logic [7:0]  awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0]  wstrb_ff, nxt_wstrb;
    logic [1:0]  bresp_ff, nxt_bresp;
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0]  rresp_ff, nxt_rresp;

    logic [7:0]  bank_select_pointer;
    logic [7:0]  condition_flags;
    logic [1:0]  interrupt_mask_level;
    assign bank_select_pointer  = psw_ff[15:8];
    assign condition_flags      = psw_ff[7:0];
    assign interrupt_mask_level = psw_ff[`CPUSR_BIT_IL1:`CPUSR_BIT_IL0];

    // ALU flag computation
    logic [16:0] sum;
    logic [7:0]  res8;
    logic [15:0] res16;
    logic        f_h, f_n, f_z, f_v, f_c;
    always_comb begin
        sum   = 17'h00000;
        res16 = acc_ff;
        f_h   = 1'b0;
        f_v   = 1'b0;
        f_c   = 1'b0;
        unique case (i_alu_op)
            CPUSR_OP_ADD: begin
                sum = {1'b0, acc_ff} + {1'b0, tmp_ff};
                res16 = sum[15:0];
                f_h = ({1'b0, acc_ff[3:0]} + {1'b0, tmp_ff[3:0]}) > 5'h0f;
                f_c = i_alu_wide ? sum[16]
                      : (({1'b0, acc_ff[7:0]} + {1'b0, tmp_ff[7:0]}) > 9'h0ff);
                f_v = i_alu_wide
                    ? (acc_ff[15] == tmp_ff[15]) && (res16[15] != acc_ff[15])
                    : (acc_ff[7] == tmp_ff[7]) && (res16[7] != acc_ff[7]);
            end
            CPUSR_OP_SUB: begin
                sum = {1'b0, acc_ff} - {1'b0, tmp_ff};
                res16 = sum[15:0];
                f_h = acc_ff[3:0] < tmp_ff[3:0];
                f_c = i_alu_wide ? (acc_ff < tmp_ff)
                                 : (acc_ff[7:0] < tmp_ff[7:0]);
                f_v = i_alu_wide
                    ? (acc_ff[15] != tmp_ff[15]) && (res16[15] != acc_ff[15])
                    : (acc_ff[7] != tmp_ff[7]) && (res16[7] != acc_ff[7]);
            end
            CPUSR_OP_SHL: begin
                res16 = {acc_ff[14:0], 1'b0};
                f_c = i_alu_wide ? acc_ff[15] : acc_ff[7];
            end
            CPUSR_OP_SHR: begin
                res16 = i_alu_wide ? {1'b0, acc_ff[15:1]}
                                   : {acc_ff[15:8], 1'b0, acc_ff[7:1]};
                f_c = acc_ff[0];
            end
            CPUSR_OP_PASS: begin
                res16 = tmp_ff;
            end
            default: res16 = acc_ff;
        endcase
        res8 = res16[7:0];
        f_n = i_alu_wide ? res16[15] : res8[7];
        f_z = i_alu_wide ? (res16 == 16'h0000) : (res8 == 8'h00);
    end

    logic [15:0] gpr_addr_c;
    always_comb begin
        gpr_addr_c = `CPUSR_BANK_BASE
                   + {9'h000, bank_select_pointer[3:0], 3'h0}
                   + {13'h0000, ridx_ff};
    end

    // Bus write handshake
    logic aw_take, w_take, do_write;
    assign o_s_axi_awready = (wst_ff == CPUSR_WR_IDLE) && !aw_got_ff;
    assign o_s_axi_wready  = (wst_ff == CPUSR_WR_IDLE) && !w_got_ff;
    assign aw_take  = i_s_axi_awvalid && o_s_axi_awready;
    assign w_take   = i_s_axi_wvalid && o_s_axi_wready;

    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    always_comb begin
        wr_addr  = aw_got_ff ? awaddr_ff : i_s_axi_awaddr;
        wr_data  = w_got_ff ? wdata_ff : i_s_axi_wdata;
        wr_strb  = w_got_ff ? wstrb_ff : i_s_axi_wstrb;
        do_write = (aw_got_ff || aw_take) && (w_got_ff || w_take)
                 && (wst_ff == CPUSR_WR_IDLE);
    end

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    always_comb begin
        nxt_ip     = ip_ff;
        nxt_acc    = acc_ff;
        nxt_tmp    = tmp_ff;
        nxt_ix     = ix_ff;
        nxt_ep     = ep_ff;
        nxt_sp     = sp_ff;
        nxt_psw    = psw_ff;
        nxt_rlvl   = rlvl_ff;
        nxt_ridx   = ridx_ff;
        nxt_wst    = wst_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got  = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bresp  = bresp_ff;
        if (i_alu_go) begin
            nxt_acc = i_alu_wide ? res16 : {acc_ff[15:8], res8};
            nxt_psw[`CPUSR_BIT_H] = f_h;
            nxt_psw[`CPUSR_BIT_N] = f_n;
            nxt_psw[`CPUSR_BIT_Z] = f_z;
            nxt_psw[`CPUSR_BIT_V] = f_v;
            nxt_psw[`CPUSR_BIT_C] = f_c;
        end
        nxt_ridx = i_gpr_index;
        if (aw_take) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = i_s_axi_awaddr;
        end
        if (w_take) begin
            nxt_w_got = 1'b1;
            nxt_wdata = i_s_axi_wdata;
            nxt_wstrb = i_s_axi_wstrb;
        end
        if (do_write) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_wst    = CPUSR_WR_RESP;
            nxt_bresp  = 2'b00;
            unique case (wr_addr)
                `CPUSR_OFF_IP:  nxt_ip  = merge16(ip_ff, wr_data, wr_strb);
                `CPUSR_OFF_ACC: nxt_acc = merge16(acc_ff, wr_data, wr_strb);
                `CPUSR_OFF_TMP: nxt_tmp = merge16(tmp_ff, wr_data, wr_strb);
                `CPUSR_OFF_IX:  nxt_ix  = merge16(ix_ff, wr_data, wr_strb);
                `CPUSR_OFF_EP:  nxt_ep  = merge16(ep_ff, wr_data, wr_strb);
                `CPUSR_OFF_SP:  nxt_sp  = merge16(sp_ff, wr_data, wr_strb);
                `CPUSR_OFF_PSW: nxt_psw = merge16(psw_ff, wr_data, wr_strb);
                `CPUSR_OFF_ALU, `CPUSR_OFF_IRQ, `CPUSR_OFF_GPR,
                `CPUSR_OFF_MAP: nxt_bresp = 2'b00;
                default:        nxt_bresp = 2'b10;
            endcase
        end
        if ((wst_ff == CPUSR_WR_RESP) && i_s_axi_bready)
            nxt_wst = CPUSR_WR_IDLE;
        if (o_irq_accept)
            nxt_rlvl = i_irq_level;
    end

    // Bus read path
    assign o_s_axi_arready = !rvalid_ff;
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (rvalid_ff && i_s_axi_rready)
            nxt_rvalid = 1'b0;
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = 2'b00;
            unique case (i_s_axi_araddr)
                `CPUSR_OFF_IP:  nxt_rdata = {16'h0000, ip_ff};
                `CPUSR_OFF_ACC: nxt_rdata = {16'h0000, acc_ff};
                `CPUSR_OFF_TMP: nxt_rdata = {16'h0000, tmp_ff};
                `CPUSR_OFF_IX:  nxt_rdata = {16'h0000, ix_ff};
                `CPUSR_OFF_EP:  nxt_rdata = {16'h0000, ep_ff};
                `CPUSR_OFF_SP:  nxt_rdata = {16'h0000, sp_ff};
                `CPUSR_OFF_PSW: nxt_rdata = {16'h0000, psw_ff};
                `CPUSR_OFF_ALU: nxt_rdata = {27'h0000000, f_h, f_n, f_z,
                                             f_v, f_c};
                `CPUSR_OFF_IRQ: nxt_rdata = {29'h00000000, o_irq_accept,
                                             rlvl_ff};
                `CPUSR_OFF_GPR: nxt_rdata = {15'h0000, o_gpr_valid,
                                             gpr_addr_c};
                `CPUSR_OFF_MAP: nxt_rdata = {14'h0000,
                                             region_of(i_mem_addr),
                                             i_mem_addr};
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = 2'b10;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            // fetch starts at the top vector
            ip_ff     <= `CPUSR_RST_IP;
            acc_ff    <= 16'h0000;
            tmp_ff    <= 16'h0000;
            ix_ff     <= 16'h0000;
            ep_ff     <= 16'h0000;
            sp_ff     <= `CPUSR_RST_SP;
            psw_ff    <= `CPUSR_RST_PSW;
            rlvl_ff   <= 2'h0;
            ridx_ff   <= 3'h0;
            wst_ff    <= CPUSR_WR_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff  <= 32'h00000000;
            wstrb_ff  <= 4'h0;
            bresp_ff  <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= 2'h0;
        end else begin
            ip_ff     <= nxt_ip;
            acc_ff    <= nxt_acc;
            tmp_ff    <= nxt_tmp;
            ix_ff     <= nxt_ix;
            ep_ff     <= nxt_ep;
            sp_ff     <= nxt_sp;
            psw_ff    <= nxt_psw;
            rlvl_ff   <= nxt_rlvl;
            ridx_ff   <= nxt_ridx;
            wst_ff    <= nxt_wst;
            aw_got_ff <= nxt_aw_got;
            w_got_ff  <= nxt_w_got;
            awaddr_ff <= nxt_awaddr;
            wdata_ff  <= nxt_wdata;
            wstrb_ff  <= nxt_wstrb;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    assign o_s_axi_bvalid = (wst_ff == CPUSR_WR_RESP);
    assign o_s_axi_bresp  = bresp_ff;
    assign o_s_axi_rvalid = rvalid_ff;
    assign o_s_axi_rdata  = rdata_ff;
    assign o_s_axi_rresp  = rresp_ff;
    assign o_irq_accept = i_irq_req && condition_flags[`CPUSR_BIT_I]
                        && level_ok(i_irq_level, interrupt_mask_level);
    assign o_gpr_addr   = gpr_addr_c;
    assign o_gpr_valid  = {1'b0, bank_select_pointer} < {1'b0, 3'h0,
                          `CPUSR_BANK_LIMIT};
    assign o_mem_region = region_of(i_mem_addr);

    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);
    a_irq_low_block: assert property (
        (i_irq_level == 2'b11) |-> !o_irq_accept)
        else $error("irq accepted at request level 3");
    a_irq_enable_gate: assert property (
        !condition_flags[`CPUSR_BIT_I] |-> !o_irq_accept)
        else $error("irq accepted while disabled");
    a_irq_prio_cmp: assert property (
        o_irq_accept |-> (i_irq_level < interrupt_mask_level))
        else $error("irq level not above mask");
    a_zero_flag_set: assert property (
        (i_alu_go && !i_alu_wide && res8 == 8'h00) |=> psw_ff[`CPUSR_BIT_Z])
        else $error("zero flag missed");
    a_neg_flag_msb: assert property (
        (i_alu_go && i_alu_wide) |=> psw_ff[`CPUSR_BIT_N] == acc_ff[15])
        else $error("negative flag wrong");
    a_acc_upper_kept: assert property (
        (i_alu_go && !i_alu_wide && !do_write) |=>
        acc_ff[15:8] == $past(acc_ff[15:8]))
        else $error("upper accumulator changed");
    a_shift_carry_out: assert property (
        (i_alu_go && i_alu_op == CPUSR_OP_SHR) |=>
        psw_ff[`CPUSR_BIT_C] == $past(acc_ff[0]))
        else $error("shift carry wrong");
    a_gpr_addr_form: assert property (
        o_gpr_addr[2:0] == ridx_ff && o_gpr_addr[15:7] == 9'h002)
        else $error("register address malformed");
    a_bank_half_only: assert property (
        psw_ff[11] |-> !o_gpr_valid)
        else $error("upper bank reported usable");
    c_irq_taken: cover property (@(posedge i_sys_clk) o_irq_accept);
    c_add_carry: cover property (@(posedge i_sys_clk)
        i_alu_go && i_alu_op == CPUSR_OP_ADD && f_c);
    c_write_resp: cover property (@(posedge i_sys_clk) o_s_axi_bvalid);
endmodule

// >>> test/cpusr_core_tb.sv
`timescale 1ns/1ps
`include "cpusr_regs.svh"
module cpusr_core_tb;
    import cpusr_pkg::*;
    logic        sys_clk = 1'b0, rstn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, mem_region;
    logic [31:0] rdata;
    logic        alu_go = 1'b0, alu_wide = 1'b0, irq_req = 1'b0;
    cpusr_op_t   alu_op = CPUSR_OP_PASS;
    logic [1:0]  irq_level = 2'h0;
    logic [2:0]  gpr_index = 3'h0;
    logic [15:0] mem_addr = 16'h0, gpr_addr;
    logic        irq_accept, gpr_valid;
    int          bad_count = 0, n_tests = 0;
    logic [31:0] seed = 32'hf7b992c6;
    logic [15:0] mdl [7] = '{`CPUSR_RST_IP, 16'h0, 16'h0, 16'h0, 16'h0,
                             `CPUSR_RST_SP, `CPUSR_RST_PSW};
    logic [15:0] bnd [6] = '{16'h0000, 16'h007f, 16'h0080, 16'h7fff,
                             16'h8000, 16'hffff};

    cpusr_core cpusr_core_i (
        .i_sys_clk(sys_clk), .i_rstn(rstn),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .i_alu_go(alu_go), .i_alu_op(alu_op),
        .i_alu_wide(alu_wide), .i_irq_level(irq_level),
        .i_irq_req(irq_req), .i_gpr_index(gpr_index),
        .i_mem_addr(mem_addr), .o_irq_accept(irq_accept),
        .o_gpr_addr(gpr_addr), .o_gpr_valid(gpr_valid),
        .o_mem_region(mem_region)
    );

    always #50 sys_clk = ~sys_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Priority level of a two-bit code; codes 0 and 1 are both level 1
    function automatic int lvl(input logic [1:0] c);
        return (c == 2'h0) ? 1 : int'(c);
    endfunction

    task automatic summarize();
        $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write: both channels offered together, each released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        logic pa, pw, bd, ta, tw, tb;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        bd = 1'b0;
        r = 2'h3;
        for (int n = 0; n < 40 && !bd; n++) begin
            @(negedge sys_clk);
            ta = pa && awready;
            tw = pw && wready;
            tb = !pa && !pw && bvalid;
            if (tb) r = bresp;
            @(posedge sys_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
            bd = tb;
        end
        if (!bd) begin
            chk(32'h0, 32'h1);
            summarize();
        end
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        logic pa, rd, ta, tr;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        pa = 1'b1;
        rd = 1'b0;
        for (int n = 0; n < 40 && !rd; n++) begin
            @(negedge sys_clk);
            ta = pa && arready;
            tr = !pa && rvalid;
            if (tr) d = rdata;
            if (tr) r = rresp;
            @(posedge sys_clk);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
            pa = pa && !ta;
            rd = tr;
        end
        if (!rd) begin
            chk(32'h0, 32'h1);
            summarize();
        end
    endtask

    task automatic wreg(input int i, input logic [31:0] v);
        logic [1:0] r;
        axw(8'(i * 4), v, r);
        chk(32'(r), 32'h0);
        mdl[i] = v[15:0];
    endtask

    task automatic rchk(input int i);
        logic [31:0] d;
        logic [1:0]  r;
        axr(8'(i * 4), d, r);
        chk(d, {16'h0, mdl[i]});
    endtask

    // Reference arithmetic: result plus flags and which flags are defined
    function automatic logic [15:0] alu_ref(input int op,
        input logic [15:0] a, input logic [15:0] t, input logic w,
        output logic [7:0] f, output logic [7:0] m);
        logic [8:0]  n;
        logic [15:0] x;
        case (op)
            0: n = {1'b0, a[7:0]} + {1'b0, t[7:0]};
            1: n = {1'b0, a[7:0]} - {1'b0, t[7:0]};
            2: n = {a[7:0], 1'b0};
            3: n = {a[0], 1'b0, a[7:1]};
            default: n = {1'b0, t[7:0]};
        endcase
        case (op)
            0: x = a + t;
            1: x = a - t;
            2: x = a << 1;
            3: x = a >> 1;
            default: x = t;
        endcase
        f = {1'b0, 3'h0, n[7], n[7:0] == 8'h0, 1'b0, n[8]};
        f[7] = (op == 0) ? (a[3:0] + t[3:0] > 15) : (a[3:0] < t[3:0]);
        f[1] = (a[7] ^ n[7]) & ((op == 0) ? ~(a[7] ^ t[7]) : (a[7] ^ t[7]));
        m = (op < 2) ? 8'h8f : (op == 2) ? 8'h0d : (op == 3) ? 8'h05 : 8'h0;
        if (w) m = 8'h0;
        return w ? x : {a[15:8], n[7:0]};
    endfunction

    initial begin
        int          i, k;
        logic [31:0] d, g;
        logic [1:0]  r, q;
        logic [15:0] a, t, p, e, mk;
        logic [7:0]  b, f, m;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        for (i = 0; i < 7; i++) rchk(i);
        for (k = 0; k < 14; k++) begin
            wreg(k % 7, rnd());
            rchk(k % 7);
        end
        axw(8'h2c, rnd(), r);
        chk(32'(r), 32'h2);
        axr(8'h2c, d, r);
        chk({d[31:2], r}, 32'h2);
        for (k = 0; k < 40; k++) begin
            a = 16'(rnd());
            t = 16'(rnd());
            p = 16'(rnd());
            g = rnd();
            wreg(1, {16'h0, a});
            wreg(2, {16'h0, t});
            wreg(6, {16'h0, p});
            alu_op <= cpusr_op_t'(3'(k % 5));
            alu_wide <= g[0];
            alu_go <= 1'b1;
            @(posedge sys_clk);
            alu_go <= 1'b0;
            e = alu_ref(k % 5, a, t, g[0], f, m);
            mdl[1] = e;
            rchk(1);
            mk = {8'hff, 8'h70 | m};
            axr(8'h18, d, r);
            chk(d & mk, {p[15:8], p[7:0] & 8'h70 | f} & mk);
        end
        q = 2'h0;
        for (k = 0; k < 64; k++) begin
            wreg(6, {25'h0, k[4], k[3:2], 4'h0});
            irq_level <= k[1:0];
            irq_req <= k[5];
            i = k[5] & k[4] & (lvl(k[1:0]) < lvl(k[3:2]));
            if (i != 0) begin
                q = k[1:0];
            end
            @(negedge sys_clk);
            chk(32'(irq_accept), 32'(i));
            @(posedge sys_clk);
            axr(8'h20, d, r);
            chk(d, {29'h0, i[0], q});
            irq_req <= 1'b0;
        end
        for (k = 0; k < 18; k++) begin
            b = (k < 16) ? 8'(k) : 8'(k + 16);
            g = rnd();
            wreg(6, {16'h0, b, 8'h30});
            gpr_index <= g[2:0];
            @(posedge sys_clk);
            @(negedge sys_clk);
            e = 16'(`CPUSR_BANK_BASE + {b[3:0], g[2:0]});
            chk({15'h0, gpr_valid, gpr_addr},
                {15'h0, b < 8'h8, e});
            @(posedge sys_clk);
            axr(8'h24, d, r);
            chk(d, {15'h0, b < 8'h8, e});
        end
        for (k = 0; k < 16; k++) begin
            g = rnd();
            a = (k < 6) ? bnd[k] : g[15:0];
            mem_addr <= a;
            i = (a <= `CPUSR_IO_TOP) ? 0 : (a <= `CPUSR_DATA_TOP) ? 1 : 2;
            @(negedge sys_clk);
            chk(32'(mem_region), 32'(i));
            @(posedge sys_clk);
            axr(8'h28, d, r);
            chk(d, {14'h0, 2'(i), a});
        end
        summarize();
    end
endmodule
